// File: core/rhd_pkg.sv
package rhd_pkg;
  // -------------------------------------------------------------------
  // command codes on the shared microprocessor bus
  // -------------------------------------------------------------------
  localparam logic [7:0] CMD_RD_A = 8'h12; // read port config a
  localparam logic [7:0] CMD_RD_B = 8'h13; // read port config b
  localparam logic [7:0] CMD_WR_A = 8'h92; // write port config a
  localparam logic [7:0] CMD_WR_B = 8'h93; // write port config b

  // -------------------------------------------------------------------
  // field positions, config a
  // -------------------------------------------------------------------
  localparam int A_WAIT_LSB = 24; // power good wait, 31..24
  localparam int A_WAIT_W = 8;
  localparam int A_NO_OC = 12; // no overcurrent report
  localparam int A_OC_PP = 11; // overcurrent per port
  localparam int A_COMPOUND = 10; // compound flag, always zero
  localparam int A_ALWAYS_PWR = 9; // always powered
  localparam int A_PP_SW = 8; // per port switching
  localparam int A_COUNT_LSB = 0; // port count, 1..0
  localparam int A_COUNT_W = 2;

  // -------------------------------------------------------------------
  // field positions, config b
  // -------------------------------------------------------------------
  localparam int B_MASK_LSB = 16; // port power mask, 18..16
  localparam int B_FIX_LSB = 0; // fixed device flags, 2..0
  localparam int B_FIELD_W = 3;
  localparam int PORT_LO = 1; // first real port bit
  localparam int PORT_HI = 2; // last real port bit

  // -------------------------------------------------------------------
  // timing: unit of the power good wait
  // -------------------------------------------------------------------
  localparam int WAIT_UNIT_MS = 2;
  localparam int CLK_HZ = 50_000_000;
  localparam int WAIT_UNIT_CYC = WAIT_UNIT_MS * (CLK_HZ / 1000);

  // half word widths of the 16-bit data path
  localparam int HALF_W = 16;

  // access sequencer states
  typedef enum logic [2:0] {
    RHD_IDLE,
    RHD_WR_LO,
    RHD_WR_HI,
    RHD_RD_LO,
    RHD_RD_HI
  } rhd_state_type;

  // writable content of config a
  typedef struct packed {
    logic [A_WAIT_W-1:0] power_good_wait;
    logic no_overcurrent_report;
    logic overcurrent_per_port;
    logic always_powered;
    logic per_port_switching;
  } rhd_cfg_a_type;

  // writable content of config b
  typedef struct packed {
    logic [B_FIELD_W-1:0] port_power_mask;
    logic [B_FIELD_W-1:0] fixed_device_flags;
  } rhd_cfg_b_type;
endpackage : rhd_pkg

// File: core/rhd_root_port_config.sv
`timescale 1ns/1ps
// Functional notes
// - top byte of a: wait, units of 2 ms
// - no-overcurrent bit disables reporting entirely
// - overcurrent mode resets to switching mode
// - overcurrent mode: collective or per port
// - compound bit reads zero, ignores writes
// - always-powered bit overrides power switching
// - switching mode zero powers ports together
// - masked port obeys only per-port commands; here only in per-port switching mode, ganged mode puts it on global commands
// - unmasked port obeys only global commands
// - port count read-only, at most two
// - b mask and removable fields writable
// - field bit0 reserved, bits1-2 are ports
module rhd_root_port_config #(
  parameter int PORTS = 2, // downstream ports, at most two
  parameter logic [7:0] WAIT_RESET = 8'h01, // power good wait at reset
  parameter logic NO_OC_RESET = 1'b0, // no overcurrent at reset
  parameter logic ALWAYS_PWR_RESET = 1'b0, // always powered at reset
  parameter logic PP_SW_RESET = 1'b1, // per port switching at reset
  parameter logic [2:0] MASK_RESET = 3'h0, // power mask at reset
  parameter logic [2:0] FIX_RESET = 3'h0 // device flags at reset
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmd_strobe, // command code written
  input wire logic [7:0] cmd_code,
  input wire logic data_wr_strobe, // one half word written
  input wire logic [15:0] data_wr,
  input wire logic data_rd_strobe, // current half word consumed
  output logic [15:0] data_rd, // half word on offer
  output rhd_pkg::rhd_cfg_a_type cfg_a, // settings of config a
  output rhd_pkg::rhd_cfg_b_type cfg_b, // settings of config b
  output logic [1:0] port_count,
  output logic ports_switched, // ports have power switches
  output logic [2:0] port_global_ctrl, // per port: follows global cmd
  output logic [2:0] port_local_ctrl, // per port: follows port cmd
  output logic oc_collective, // overcurrent reported as a group
  output logic oc_per_port, // overcurrent reported per port
  output logic [31:0] wait_cycles // power good wait in clocks
);

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  // port count clamps to two, a wider hub is not buildable here
  localparam logic [1:0] COUNT =
    (PORTS > rhd_pkg::PORT_HI) ? 2'(rhd_pkg::PORT_HI) : 2'(PORTS);
  localparam logic [2:0] PORT_BITS = 3'h6; // bits 1 and 2 only

  // the 32-bit image of config a, reserved and compound bits as zero
  function automatic logic [31:0] rhd_image_a(rhd_pkg::rhd_cfg_a_type a);
    logic [31:0] w;
    w = '0;
    w[rhd_pkg::A_WAIT_LSB +: rhd_pkg::A_WAIT_W] = a.power_good_wait;
    w[rhd_pkg::A_NO_OC] = a.no_overcurrent_report;
    w[rhd_pkg::A_OC_PP] = a.overcurrent_per_port;
    w[rhd_pkg::A_COMPOUND] = 1'b0;
    w[rhd_pkg::A_ALWAYS_PWR] = a.always_powered;
    w[rhd_pkg::A_PP_SW] = a.per_port_switching;
    w[rhd_pkg::A_COUNT_LSB +: rhd_pkg::A_COUNT_W] = COUNT;
    return w;
  endfunction : rhd_image_a

  // the 32-bit image of config b
  function automatic logic [31:0] rhd_image_b(rhd_pkg::rhd_cfg_b_type b);
    logic [31:0] w;
    w = '0;
    w[rhd_pkg::B_MASK_LSB +: rhd_pkg::B_FIELD_W] = b.port_power_mask;
    w[rhd_pkg::B_FIX_LSB +: rhd_pkg::B_FIELD_W] = b.fixed_device_flags;
    return w;
  endfunction : rhd_image_b

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  rhd_pkg::rhd_state_type state, next_state; // access sequencer
  logic target_b, next_target_b; // access aims at config b
  logic [15:0] low_half, next_low_half; // staged low half of a write
  logic [31:0] rd_word, next_rd_word; // snapshot taken at read cmd
  logic [15:0] next_data_rd;
  rhd_pkg::rhd_cfg_a_type next_cfg_a;
  rhd_pkg::rhd_cfg_b_type next_cfg_b;
  logic [31:0] wr_word; // assembled write word

  // -------------------------------------------------------------------
  // access sequencer: command, then two half words, low first
  // -------------------------------------------------------------------
  // a new command aborts any half-finished access; a write only
  // lands when its high half arrives, so a torn write changes nothing
  always_comb begin
    next_state = state;
    next_target_b = target_b;
    next_low_half = low_half;
    next_rd_word = rd_word;
    next_data_rd = data_rd;
    next_cfg_a = cfg_a;
    next_cfg_b = cfg_b;
    wr_word = {data_wr, low_half};
    if (cmd_strobe) begin
      unique case (cmd_code)
        rhd_pkg::CMD_WR_A, rhd_pkg::CMD_WR_B: begin
          next_state = rhd_pkg::RHD_WR_LO;
          next_target_b = (cmd_code == rhd_pkg::CMD_WR_B);
        end
        rhd_pkg::CMD_RD_A: begin
          next_state = rhd_pkg::RHD_RD_LO;
          next_rd_word = rhd_image_a(cfg_a);
          // low half offered from the fresh snapshot
          next_data_rd = next_rd_word[rhd_pkg::HALF_W-1:0];
        end
        rhd_pkg::CMD_RD_B: begin
          next_state = rhd_pkg::RHD_RD_LO;
          next_rd_word = rhd_image_b(cfg_b);
          next_data_rd = next_rd_word[rhd_pkg::HALF_W-1:0];
        end
        default: begin
          // codes of other registers are not ours: drop back to idle
          next_state = rhd_pkg::RHD_IDLE;
        end
      endcase
    end else begin
      unique case (state)
        rhd_pkg::RHD_IDLE: begin
          next_state = rhd_pkg::RHD_IDLE;
        end
        rhd_pkg::RHD_WR_LO: begin
          if (data_wr_strobe) begin
            next_low_half = data_wr;
            next_state = rhd_pkg::RHD_WR_HI;
          end
        end
        rhd_pkg::RHD_WR_HI: begin
          if (data_wr_strobe) begin
            next_state = rhd_pkg::RHD_IDLE;
            if (target_b) begin
              // only the port bits of each field take a write
              next_cfg_b.port_power_mask = PORT_BITS &
                wr_word[rhd_pkg::B_MASK_LSB +: rhd_pkg::B_FIELD_W];
              next_cfg_b.fixed_device_flags = PORT_BITS &
                wr_word[rhd_pkg::B_FIX_LSB +: rhd_pkg::B_FIELD_W];
            end else begin
              next_cfg_a.power_good_wait =
                wr_word[rhd_pkg::A_WAIT_LSB +: rhd_pkg::A_WAIT_W];
              next_cfg_a.no_overcurrent_report =
                wr_word[rhd_pkg::A_NO_OC];
              next_cfg_a.overcurrent_per_port =
                wr_word[rhd_pkg::A_OC_PP];
              next_cfg_a.always_powered =
                wr_word[rhd_pkg::A_ALWAYS_PWR];
              next_cfg_a.per_port_switching =
                wr_word[rhd_pkg::A_PP_SW];
            end
          end
        end
        rhd_pkg::RHD_RD_LO: begin
          if (data_rd_strobe) begin
            next_data_rd = rd_word[2*rhd_pkg::HALF_W-1:rhd_pkg::HALF_W];
            next_state = rhd_pkg::RHD_RD_HI;
          end
        end
        rhd_pkg::RHD_RD_HI: begin
          if (data_rd_strobe) begin
            next_state = rhd_pkg::RHD_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= rhd_pkg::RHD_IDLE;
      target_b <= 1'b0;
      low_half <= '0;
      rd_word <= '0;
      data_rd <= '0;
      cfg_a.power_good_wait <= WAIT_RESET;
      cfg_a.no_overcurrent_report <= NO_OC_RESET;
      cfg_a.overcurrent_per_port <= PP_SW_RESET;
      cfg_a.always_powered <= ALWAYS_PWR_RESET;
      cfg_a.per_port_switching <= PP_SW_RESET;
      cfg_b.port_power_mask <= MASK_RESET & PORT_BITS;
      cfg_b.fixed_device_flags <= FIX_RESET & PORT_BITS;
    end else begin
      state <= next_state;
      target_b <= next_target_b;
      low_half <= next_low_half;
      rd_word <= next_rd_word;
      data_rd <= next_data_rd;
      cfg_a <= next_cfg_a;
      cfg_b <= next_cfg_b;
    end
  end

  // -------------------------------------------------------------------
  // steering outputs decoded from the settings
  // -------------------------------------------------------------------
  logic next_ports_switched;
  logic [2:0] next_global, next_local;
  logic next_oc_coll, next_oc_pp;
  logic [31:0] next_wait_cycles;

  // decoded from the next settings so all outputs are flops that change on the same edge as the settings
  always_comb begin
    next_ports_switched = !next_cfg_a.always_powered;
    next_global = '0;
    next_local = '0;
    if (next_ports_switched) begin
      if (next_cfg_a.per_port_switching) begin
        next_local = next_cfg_b.port_power_mask & PORT_BITS;
        next_global = ~next_cfg_b.port_power_mask & PORT_BITS;
      end else begin
        next_global = PORT_BITS;
      end
    end
    // mode bit only counts while reporting is enabled
    next_oc_coll = !next_cfg_a.no_overcurrent_report &&
      !next_cfg_a.overcurrent_per_port;
    next_oc_pp = !next_cfg_a.no_overcurrent_report &&
      next_cfg_a.overcurrent_per_port;
    next_wait_cycles = 32'(next_cfg_a.power_good_wait) *
      32'(rhd_pkg::WAIT_UNIT_CYC);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_count <= '0;
      ports_switched <= 1'b0;
      port_global_ctrl <= '0;
      port_local_ctrl <= '0;
      oc_collective <= 1'b0;
      oc_per_port <= 1'b0;
      wait_cycles <= '0;
    end else begin
      port_count <= COUNT;
      ports_switched <= next_ports_switched;
      port_global_ctrl <= next_global;
      port_local_ctrl <= next_local;
      oc_collective <= next_oc_coll;
      oc_per_port <= next_oc_pp;
      wait_cycles <= next_wait_cycles;
    end
  end

endmodule : rhd_root_port_config

// File: sim/rhd_root_port_config_asserts.sv
`timescale 1ns/1ps
// ---------------------------------------------
// port checks of the descriptor register pair
// ---------------------------------------------
module rhd_cfg_asserts (
  input logic ref_clk,
  input logic rst_n,
  input logic cmd_strobe,
  input logic [7:0] cmd_code,
  input logic data_wr_strobe,
  input logic [15:0] data_wr,
  input logic [15:0] data_rd,
  input rhd_pkg::rhd_cfg_a_type cfg_a,
  input rhd_pkg::rhd_cfg_b_type cfg_b,
  input logic [1:0] port_count,
  input logic ports_switched,
  input logic [2:0] port_global_ctrl,
  input logic [2:0] port_local_ctrl,
  input logic oc_collective,
  input logic oc_per_port,
  input logic [31:0] wait_cycles
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic live; // low on the first edge after reset, derived values lag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) live <= 1'b0;
    else live <= 1'b1;
  end
  // two data halves with no command cutting in
  sequence s_halves;
    !cmd_strobe && data_wr_strobe ##1 !cmd_strobe && data_wr_strobe;
  endsequence
  AST_COUNT: assert property (live |-> port_count == 2'd2)
    else $error("port count not two");
  AST_RSVD_B: assert property (!cfg_b.port_power_mask[0]
    && !cfg_b.fixed_device_flags[0]) else $error("reserved b bit set");
  AST_SWITCHED: assert property (live |->
    ports_switched == !cfg_a.always_powered) else $error("switched bad");
  AST_OC_COLL: assert property (live |-> oc_collective ==
    (!cfg_a.no_overcurrent_report && !cfg_a.overcurrent_per_port))
    else $error("collective report bad");
  AST_OC_PP: assert property (live |-> oc_per_port ==
    (!cfg_a.no_overcurrent_report && cfg_a.overcurrent_per_port))
    else $error("per port report bad");
  AST_GANG: assert property (live && !cfg_a.always_powered
    && !cfg_a.per_port_switching |-> port_global_ctrl == 3'h6
    && port_local_ctrl == 3'h0) else $error("ganged power bad");
  AST_MASK: assert property (live && !cfg_a.always_powered
    && cfg_a.per_port_switching |-> port_local_ctrl ==
    (cfg_b.port_power_mask & 3'h6) && port_global_ctrl ==
    (~cfg_b.port_power_mask & 3'h6)) else $error("mask ctrl bad");
  AST_WAIT: assert property (live |-> wait_cycles ==
    cfg_a.power_good_wait * 32'd100000) else $error("wait bad");
  AST_WR_A: assert property (cmd_strobe && cmd_code == 8'h92
    ##1 s_halves |=> cfg_a.power_good_wait == $past(data_wr[15:8]))
    else $error("wait not written");
  AST_WR_B: assert property (cmd_strobe && cmd_code == 8'h93
    ##1 s_halves |=> cfg_b.port_power_mask == {$past(data_wr[2:1]),
    1'b0}) else $error("mask not written");
  AST_RD_A: assert property (cmd_strobe && cmd_code == 8'h12
    |=> data_rd == {3'h0, cfg_a.no_overcurrent_report,
    cfg_a.overcurrent_per_port, 1'b0, cfg_a.always_powered,
    cfg_a.per_port_switching, 8'h02}) else $error("read a bad");
  AST_RD_B: assert property (cmd_strobe && cmd_code == 8'h13
    |=> data_rd == {13'h0, cfg_b.fixed_device_flags})
    else $error("read b bad");
endmodule : rhd_cfg_asserts

bind rhd_root_port_config rhd_cfg_asserts u_chk (.ref_clk(ref_clk),
  .rst_n(rst_n), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
  .data_wr_strobe(data_wr_strobe), .data_wr(data_wr),
  .data_rd(data_rd), .cfg_a(cfg_a), .cfg_b(cfg_b),
  .port_count(port_count), .ports_switched(ports_switched),
  .port_global_ctrl(port_global_ctrl), .port_local_ctrl(port_local_ctrl),
  .oc_collective(oc_collective), .oc_per_port(oc_per_port),
  .wait_cycles(wait_cycles));

// File: sim/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
  // ---------------------------------------------
  // stimulus, observed ports and model images
  // ---------------------------------------------
  logic ref_clk = 0, rst_n = 0, cmd_strobe = 0, data_wr_strobe = 0;
  logic data_rd_strobe = 0;
  logic [7:0] cmd_code = 8'h00;
  logic [15:0] data_wr = 16'h0000, data_rd;
  rhd_pkg::rhd_cfg_a_type cfg_a;
  rhd_pkg::rhd_cfg_b_type cfg_b;
  logic [1:0] port_count;
  logic ports_switched, oc_collective, oc_per_port;
  logic [2:0] port_global_ctrl, port_local_ctrl, gl, lc;
  logic [31:0] wait_cycles, w;
  logic [31:0] img_a = 32'h0100_0902, img_b = 32'h0000_0000; // model
  int mismatches = 0, n_checks = 0, seed = 59, i;
  always #10 ref_clk = ~ref_clk;
  rhd_root_port_config DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
    .data_wr_strobe(data_wr_strobe), .data_wr(data_wr),
    .data_rd_strobe(data_rd_strobe), .data_rd(data_rd), .cfg_a(cfg_a),
    .cfg_b(cfg_b), .port_count(port_count),
    .ports_switched(ports_switched), .port_global_ctrl(port_global_ctrl),
    .port_local_ctrl(port_local_ctrl), .oc_collective(oc_collective),
    .oc_per_port(oc_per_port), .wait_cycles(wait_cycles));
  // command, then low and high half; data garbled once released
  task automatic wr(input logic [7:0] c, input logic [31:0] v);
    @(negedge ref_clk); cmd_strobe = 1; cmd_code = c;
    @(negedge ref_clk); cmd_strobe = 0; data_wr_strobe = 1;
    data_wr = v[15:0];
    @(negedge ref_clk); data_wr = v[31:16];
    @(negedge ref_clk); data_wr_strobe = 0; data_wr = ~data_wr;
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [31:0] e);
    @(negedge ref_clk); cmd_strobe = 1; cmd_code = c;
    @(negedge ref_clk); cmd_strobe = 0; data_rd_strobe = 1;
    `CHK(data_rd, e[15:0])
    @(negedge ref_clk); `CHK(data_rd, e[31:16])
    @(negedge ref_clk); data_rd_strobe = 0;
  endtask : rd
  // outputs against the model, then both registers read back
  task automatic chk_all;
    gl = img_a[8] ? ~img_b[18:16] & 3'h6 : 3'h6;
    lc = img_a[8] ? img_b[18:16] & 3'h6 : 3'h0;
    if (img_a[9]) begin gl = 3'h0; lc = 3'h0; end // always powered
    `CHK(cfg_a, {img_a[31:24], img_a[12:11], img_a[9:8]})
    `CHK(cfg_b, {img_b[18:16], img_b[2:0]})
    `CHK(port_count, 2'd2)
    `CHK(ports_switched, !img_a[9])
    `CHK(oc_collective, !img_a[12] && !img_a[11])
    `CHK(oc_per_port, !img_a[12] && img_a[11])
    `CHK(port_global_ctrl, gl)
    `CHK(port_local_ctrl, lc)
    `CHK(wait_cycles, img_a[31:24] * 32'd100000)
    rd(rhd_pkg::CMD_RD_A, img_a);
    rd(rhd_pkg::CMD_RD_B, img_b);
  endtask : chk_all
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  initial begin
    // bound well above the roughly 800 cycles a clean run needs
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    test_done;
  end
  initial begin
    repeat (8) @(negedge ref_clk);
    rst_n = 1;
    @(negedge ref_clk); chk_all;
    $display("test reset values done");
    // every mode pattern, then random words; oc mode cleared then set
    for (i = 0; i < 48; i++) begin
      w = $random(seed);
      if (i < 32) w[12:8] = i[4:0];
      wr(rhd_pkg::CMD_WR_A, w);
      img_a = (w & 32'hFF00_1B00) | 32'h0000_0002;
      w = $random(seed);
      wr(rhd_pkg::CMD_WR_B, w);
      img_b = w & 32'h0006_0006;
      chk_all;
    end
    $display("test writes done");
    // unknown code aborts a pending write
    @(negedge ref_clk); cmd_strobe = 1; cmd_code = rhd_pkg::CMD_WR_A;
    @(negedge ref_clk); cmd_code = 8'h55;
    @(negedge ref_clk); cmd_strobe = 0; data_wr_strobe = 1;
    data_wr = 16'hFFFF;
    @(negedge ref_clk); @(negedge ref_clk); data_wr_strobe = 0;
    chk_all;
    $display("test abort done");
    // second reset in mid run
    @(negedge ref_clk); rst_n = 0;
    img_a = 32'h0100_0902; img_b = 32'h0000_0000;
    @(negedge ref_clk); `CHK(cfg_a, 12'h015)
    `CHK(port_count, 2'd0)
    @(negedge ref_clk); rst_n = 1;
    @(negedge ref_clk); chk_all;
    $display("test second reset done");
    test_done;
  end
endmodule : tb
